// ===== logic/bfms_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Soft-start begins only once the bias rail passes its power-on threshold.
// - Soft-start pin below 1V keeps both gates tri-stated, no switching.
// - Soft-start capacitor charges from a 10uA source from 0V to 3.3V.
// - Reference follows the ramp, 0V to 0.6V as pin goes 1V to 1.6V.
// - Switch node below overcurrent threshold with high side on ends the pulse.
// - Eight consecutive overcurrent cycles outside soft-start start hiccup.
// - Hiccup discharges, runs three dummy ramps, output ramps on the fourth.
// - Pulse limiting stays active in soft-start; hiccup counter held reset.
// - Margining switches its current onto feedback, sign by direction.
// - Margin slew charges or discharges the delay capacitor at 100uA.
// - Delay capacitor belongs to power-good when low, margining when high.
// - Mode pin high disables margining; select A picks internal reference.
// - Power-good needs feedback within 10 percent and a finished ramp.
// - After ramp, charge delay capacitor to 2.5V, discharge, then power-good.
// - Power-good drops after a 1us filter once feedback leaves the window.
// - Switching stops above 150C and resumes at 130C.
// - Feedback under 15 percent for eight cycles enters hiccup.
// - Feedback 15 percent over reference holds the low side gate on.
// - Overvoltage for 32 cycles tri-states gates; undervoltage then hiccups.
// - Each gate waits for the opposite gate-source voltage below 1V.
// - During start-up the low side turns off once switch node goes negative.
module bfms_sequencer
  import bfms_pkg::*;
#(
  parameter int PG_FILT = PG_FILTER_CYC,
  parameter int OC_N = OC_LIMIT,
  parameter int UV_N = UV_LIMIT,
  parameter int OV_N = OV_LIMIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bfms_pins_t pins,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic gate_drive_en,
  output logic ss_charge_en,
  output logic ss_discharge_en,
  output logic ref_track_en,
  output logic use_internal_ref,
  output logic margin_current_en,
  output logic margin_raise,
  output logic delay_capacitor_pin_pg_charge,
  output logic delay_capacitor_pin_slew_charge,
  output logic delay_capacitor_pin_slew_discharge,
  output logic delay_capacitor_pin_fast_discharge,
  output logic power_good,
  output logic power_good_oe
);
  localparam int FW = $clog2(PG_FILT + 1);

  if (PG_FILT < 1 || OC_N < 1 || UV_N < 1 || OV_N < 1) begin : g_bad_param
    $error("filter and fault limits must be at least one");
  end

  // Pins are asynchronous to pclk
  bfms_pins_t s1_q, s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  logic osc_q;
  logic tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= s2_q.osc_cycle;
    end
  end
  assign tick = s2_q.osc_cycle & ~osc_q;

  // Sequencing
  bfms_state_t state_q, state_d;
  logic ctrl_en_q;
  logic [1:0] dummy_q;
  logic en_ok, run, ovoff, oc_hit, uv_hit, ov_hit, ot_q;
  assign en_ok = s2_q.bias_por_ok & ctrl_en_q;
  assign run = state_q == ST_RUN;
  assign ovoff = state_q == ST_OVOFF;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: if (en_ok) state_d = ST_RAMP;
      ST_RAMP: if (s2_q.ss_at_3v3) state_d = ST_RUN;
      ST_RUN: begin
        if (oc_hit) begin
          state_d = ST_DISCH;
        end else if (uv_hit) begin
          state_d = ST_DISCH;
        end else if (ov_hit) begin
          state_d = ST_OVOFF;
        end else if (!s2_q.ss_above_1v) begin
          state_d = ST_RAMP;
        end
      end
      ST_OVOFF: if (uv_hit) state_d = ST_DISCH;
      ST_DISCH: begin
        if (s2_q.ss_empty) begin
          state_d = (dummy_q == DUMMY_CYCLES) ? ST_RAMP : ST_DUMMY;
        end
      end
      ST_DUMMY: if (s2_q.ss_at_3v3) state_d = ST_DISCH;
      default: state_d = ST_OFF;
    endcase
    if (!en_ok) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dummy_q <= 2'h0;
    end else if (run || ovoff) begin
      dummy_q <= 2'h0;
    end else if (state_q == ST_DUMMY && state_d == ST_DISCH) begin
      dummy_q <= dummy_q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_charge_en <= 1'b0;
      ss_discharge_en <= 1'b0;
      ref_track_en <= 1'b0;
    end else begin
      ss_charge_en <= state_q == ST_RAMP || state_q == ST_DUMMY;
      ss_discharge_en <= state_q == ST_DISCH;
      ref_track_en <= (state_q == ST_RAMP || run) && s2_q.ss_above_1v;
    end
  end

  // Fault counters, cleared outside ST_RUN (undervoltage also counts in ST_OVOFF) so soft-start cannot trip
  logic oc_now, oc_cycle_q;
  assign oc_now = high_side_gate & s2_q.phase_below_overcurrent_threshold_pin;

  bfms_cyc_count #(.LIMIT(OC_N)) u_oc_count (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!run),
    .tick(tick),
    .cond(oc_cycle_q | oc_now),
    .hit(oc_hit)
  );
  bfms_cyc_count #(.LIMIT(UV_N)) u_uv_count (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!(run || ovoff)),
    .tick(tick),
    .cond(s2_q.fb_below_uv),
    .hit(uv_hit)
  );
  bfms_cyc_count #(.LIMIT(OV_N)) u_ov_count (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!run),
    .tick(tick),
    .cond(s2_q.fb_above_ov),
    .hit(ov_hit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_q <= 1'b0;
    end else if (s2_q.temp_over_hi) begin
      ot_q <= 1'b1;
    end else if (s2_q.temp_below_lo) begin
      ot_q <= 1'b0;
    end
  end

  // Gate drive
  logic switching, ov_now, hs_want, ls_want, de_off_q, ov_q;
  assign switching = (state_q == ST_RAMP || run) && s2_q.ss_above_1v && !ot_q;
  assign ov_now = run & s2_q.fb_above_ov;
  assign hs_want = switching & s2_q.pwm_demand & ~oc_now & ~oc_cycle_q & ~ov_now;
  assign ls_want = switching & ((~s2_q.pwm_demand & ~de_off_q) | ov_now);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cycle_q <= 1'b0;
    end else if (oc_now) begin
      oc_cycle_q <= 1'b1;
    end else if (tick) begin
      oc_cycle_q <= 1'b0;
    end
  end

  // Set wins so a negative node at the cycle edge is not missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      de_off_q <= 1'b0;
    end else if (state_q == ST_RAMP && low_side_gate && s2_q.phase_negative) begin
      de_off_q <= 1'b1;
    end else if (tick || state_q != ST_RAMP) begin
      de_off_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_gate <= 1'b0;
      low_side_gate <= 1'b0;
      gate_drive_en <= 1'b0;
      ov_q <= 1'b0;
    end else begin
      high_side_gate <= hs_want & s2_q.ls_gs_low & ~low_side_gate;
      low_side_gate <= ls_want & s2_q.hs_gs_low & ~high_side_gate;
      gate_drive_en <= (state_q == ST_RAMP || run) && s2_q.ss_above_1v;
      ov_q <= ov_now;
    end
  end

  // Power-good and delay capacitor
  bfms_pg_t pg_q, pg_d;
  logic [FW-1:0] filt_q;
  always_comb begin
    pg_d = pg_q;
    case (pg_q)
      PG_IDLE: if (run) pg_d = PG_CHARGE;
      PG_CHARGE: if (s2_q.delay_capacitor_pin_at_2v5) pg_d = PG_DISCH;
      PG_DISCH: if (s2_q.delay_capacitor_pin_empty && s2_q.fb_in_window) pg_d = PG_HIGH;
      PG_HIGH: if (!s2_q.fb_in_window && filt_q == FW'(PG_FILT - 1)) pg_d = PG_IDLE;
      default: pg_d = PG_IDLE;
    endcase
    if (!run) begin
      pg_d = PG_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_q <= PG_IDLE;
      filt_q <= '0;
    end else begin
      pg_q <= pg_d;
      filt_q <= (pg_q == PG_HIGH && !s2_q.fb_in_window) ? filt_q + FW'(1) : '0;
    end
  end

  // Margining; both selects high keeps the previous choice
  logic mode_high, sel_on_q, sel_up_q, marg_on;
  assign mode_high = s2_q.margin_set_mode_pin;
  assign marg_on = ~mode_high & sel_on_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_on_q <= 1'b0;
      sel_up_q <= 1'b0;
    end else begin
      case ({s2_q.margin_select_a, s2_q.margin_select_b})
        2'h0: sel_on_q <= 1'b0;
        2'h1: begin
          sel_on_q <= 1'b1;
          sel_up_q <= 1'b1;
        end
        2'h2: begin
          sel_on_q <= 1'b1;
          sel_up_q <= 1'b0;
        end
        default: sel_on_q <= sel_on_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_good <= 1'b0;
      power_good_oe <= 1'b1;
      delay_capacitor_pin_pg_charge <= 1'b0;
      delay_capacitor_pin_fast_discharge <= 1'b0;
      delay_capacitor_pin_slew_charge <= 1'b0;
      delay_capacitor_pin_slew_discharge <= 1'b0;
      margin_current_en <= 1'b0;
      margin_raise <= 1'b0;
      use_internal_ref <= 1'b1;
    end else begin
      power_good <= pg_d == PG_HIGH;
      power_good_oe <= pg_d != PG_HIGH;
      delay_capacitor_pin_pg_charge <= pg_d == PG_CHARGE;
      delay_capacitor_pin_fast_discharge <= pg_d == PG_DISCH;
      delay_capacitor_pin_slew_charge <= pg_d == PG_HIGH && marg_on;
      delay_capacitor_pin_slew_discharge <= pg_d == PG_HIGH && !marg_on;
      margin_current_en <= pg_d == PG_HIGH && marg_on;
      margin_raise <= sel_up_q;
      use_internal_ref <= ~mode_high | s2_q.margin_select_a;
    end
  end

  // APB slave, one wait state
  logic [HIC_W-1:0] hic_q;
  logic [31:0] rdata;
  logic addr_ok, wr_fire;
  assign wr_fire = psel & penable & pready & pwrite;

  always_comb begin
    rdata = '0;
    addr_ok = 1'b1;
    case (paddr)
      OFS_CTRL: rdata[CTRL_EN_BIT] = ctrl_en_q;
      OFS_STATUS: begin
        rdata[ST_STATE_LSB +: 3] = state_q;
        rdata[ST_PG_BIT] = power_good;
        rdata[ST_OT_BIT] = ot_q;
        rdata[ST_OC_BIT] = oc_cycle_q;
        rdata[ST_OV_BIT] = ov_q;
        rdata[ST_MARG_BIT] = margin_current_en;
      end
      OFS_HICCUP: rdata[HIC_W-1:0] = hic_q;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_q <= CTRL_EN_RST;
    end else if (wr_fire && paddr == OFS_CTRL) begin
      ctrl_en_q <= pwdata[CTRL_EN_BIT];
    end
  end

  // Counting a new hiccup outranks a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hic_q <= '0;
    end else if ((run || ovoff) && state_d == ST_DISCH) begin
      hic_q <= (&hic_q) ? hic_q : hic_q + HIC_W'(1);
    end else if (wr_fire && paddr == OFS_CTRL && pwdata[CTRL_CLR_BIT]) begin
      hic_q <= '0;
    end
  end

  // Checks
  sequence s_hiccup_in;
    run && oc_hit && en_ok;
  endsequence
  sequence s_dummy_next;
    state_q == ST_DISCH && s2_q.ss_empty && dummy_q != DUMMY_CYCLES && en_ok;
  endsequence
  sequence s_ov_trip;
    run && ov_hit && !oc_hit && !uv_hit && en_ok;
  endsequence

  a_por_holds_off: assert property (@(posedge pclk) disable iff (!presetn)
    !s2_q.bias_por_ok |=> state_q == ST_OFF) else $error("left off without bias");
  a_low_pin_tristate: assert property (@(posedge pclk) disable iff (!presetn)
    !s2_q.ss_above_1v |=> !gate_drive_en && !high_side_gate && !low_side_gate)
    else $error("drove gates with pin low");
  a_ramp_charges: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_RAMP |=> ss_charge_en) else $error("ramp not charging");
  a_ref_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_RAMP && s2_q.ss_above_1v |=> ref_track_en) else $error("reference not tracking");
  a_oc_cuts_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    oc_now |=> !high_side_gate ##1 !high_side_gate) else $error("pulse not ended");
  a_oc_hiccup: assert property (@(posedge pclk) disable iff (!presetn)
    s_hiccup_in |=> state_q == ST_DISCH ##1 ss_discharge_en) else $error("no hiccup on overcurrent");
  a_dummy_dark: assert property (@(posedge pclk) disable iff (!presetn)
    s_dummy_next |=> state_q == ST_DUMMY ##1 !gate_drive_en) else $error("dummy ramp drove output");
  a_fourth_ramp: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_DISCH && state_d == ST_RAMP |-> dummy_q == DUMMY_CYCLES)
    else $error("output ramp before fourth cycle");
  a_ramp_no_trip: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_RAMP |-> state_d != ST_DISCH) else $error("hiccup during soft-start");
  a_margin_gate: assert property (@(posedge pclk) disable iff (!presetn)
    margin_current_en |-> power_good && !$past(mode_high)) else $error("margin current while off");
  a_both_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    s2_q.margin_select_a && s2_q.margin_select_b |=> $stable(sel_on_q) && $stable(sel_up_q))
    else $error("both selects changed margin");
  a_slew_owner: assert property (@(posedge pclk) disable iff (!presetn)
    !power_good |-> !delay_capacitor_pin_slew_charge && !delay_capacitor_pin_slew_discharge && !margin_current_en)
    else $error("slew used delay capacitor");
  a_ref_select: assert property (@(posedge pclk) disable iff (!presetn)
    mode_high |=> use_internal_ref == $past(s2_q.margin_select_a)) else $error("wrong reference");
  a_pg_needs_window: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(power_good) |-> $past(s2_q.fb_in_window) && $past(pg_q) == PG_DISCH && $past(run))
    else $error("power-good raised early");
  // Helper count of out-of-window cycles while good; saturates so it never wraps
  logic [FW-1:0] out_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_cnt_q <= '0;
    end else if (power_good && !s2_q.fb_in_window) begin
      out_cnt_q <= (out_cnt_q == FW'(PG_FILT)) ? out_cnt_q : out_cnt_q + FW'(1);
    end else begin
      out_cnt_q <= '0;
    end
  end

  a_pg_filter: assert property (@(posedge pclk) disable iff (!presetn)
    power_good && !s2_q.fb_in_window && out_cnt_q == FW'(PG_FILT - 1) |=> !power_good)
    else $error("power-good held too long");
  a_pg_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    power_good && !s2_q.fb_in_window && filt_q == '0 && run |=> power_good)
    else $error("power-good dropped unfiltered");
  a_hot_stop: assert property (@(posedge pclk) disable iff (!presetn)
    ot_q |=> !high_side_gate && !low_side_gate) else $error("switching while hot");
  a_uv_hiccup: assert property (@(posedge pclk) disable iff (!presetn)
    run && uv_hit && !oc_hit && en_ok |=> state_q == ST_DISCH) else $error("no hiccup on undervoltage");
  a_ov_low_on: assert property (@(posedge pclk) disable iff (!presetn)
    ov_now && switching && s2_q.hs_gs_low && !high_side_gate |=> low_side_gate)
    else $error("low side not held on");
  a_ov_tristate: assert property (@(posedge pclk) disable iff (!presetn)
    s_ov_trip |=> state_q == ST_OVOFF ##1 !gate_drive_en) else $error("gates not tri-stated");
  a_dead_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(high_side_gate) |-> $past(s2_q.ls_gs_low) && !$past(low_side_gate))
    else $error("high side overlapped low side");
  a_pre_bias: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_RAMP && low_side_gate && s2_q.phase_negative) ##1 (!tick && state_q == ST_RAMP)
    |=> !low_side_gate) else $error("low side stayed on negative node");
endmodule // bfms_sequencer
`default_nettype wire

// ===== logic/bfms_pkg.sv
`default_nettype none
package bfms_pkg;
  // APB map
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] OFS_HICCUP = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PG_BIT = 3;
  localparam int ST_OT_BIT = 4;
  localparam int ST_OC_BIT = 5;
  localparam int ST_OV_BIT = 6;
  localparam int ST_MARG_BIT = 7;
  localparam int HIC_W = 8;
  // Consecutive PWM cycle limits and dummy ramp count
  localparam int OC_LIMIT = 8;
  localparam int UV_LIMIT = 8;
  localparam int OV_LIMIT = 32;
  localparam logic [1:0] DUMMY_CYCLES = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PG_FILTER_NS = 1000;
  localparam int PG_FILTER_CYC = (PG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RAMP = 3'h1,
    ST_RUN = 3'h3,
    ST_DISCH = 3'h2,
    ST_DUMMY = 3'h6,
    ST_OVOFF = 3'h7
  } bfms_state_t;

  typedef enum logic [1:0] {
    PG_IDLE = 2'h0,
    PG_CHARGE = 2'h1,
    PG_DISCH = 2'h3,
    PG_HIGH = 2'h2
  } bfms_pg_t;

  // Comparator and strap levels arriving from the analog side
  typedef struct packed {
    logic bias_por_ok;
    logic ss_above_1v;
    logic ss_at_3v3;
    logic ss_empty;
    logic pwm_demand;
    logic osc_cycle;
    logic phase_below_overcurrent_threshold_pin;
    logic phase_negative;
    logic hs_gs_low;
    logic ls_gs_low;
    logic fb_in_window;
    logic fb_below_uv;
    logic fb_above_ov;
    logic temp_over_hi;
    logic temp_below_lo;
    logic delay_capacitor_pin_at_2v5;
    logic delay_capacitor_pin_empty;
    logic margin_set_mode_pin;
    logic margin_select_a;
    logic margin_select_b;
  } bfms_pins_t;
endpackage
`default_nettype wire

// ===== logic/bfms_cyc_count.sv
`timescale 1ns/100ps
`default_nettype none
module bfms_cyc_count
  import bfms_pkg::*;
#(
  parameter int LIMIT = OC_LIMIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick,
  input wire logic cond,
  output logic hit
);
  localparam int CW = $clog2(LIMIT + 1);
  logic [CW-1:0] cnt_q;

  if (LIMIT < 1) begin : g_bad_limit
    $error("LIMIT must be at least one");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (!cond) begin
        cnt_q <= '0;
      end else if (cnt_q != CW'(LIMIT)) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign hit = cnt_q == CW'(LIMIT);

  a_count_clean: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !cond && !clear |=> cnt_q == '0) else $error("count survived a clean cycle");
  a_count_held: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> !hit) else $error("count not held in reset");
endmodule // bfms_cyc_count
`default_nettype wire

// ===== verif/bfms_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module bfms_stage_model
  import bfms_pkg::*;
(
  input wire logic pclk,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic ss_charge_en,
  input wire logic ss_discharge_en,
  input wire logic delay_capacitor_pin_pg_charge,
  input wire logic delay_capacitor_pin_fast_discharge,
  input wire logic bias_ok,
  input wire logic oc,
  input wire logic uv,
  input wire logic ov,
  input wire logic hot,
  input wire logic [2:0] strap,
  output var bfms_pins_t pins
);
  // Capacitor levels in 0.1V steps
  logic [5:0] ss_v = 6'h00;
  logic [4:0] cd_v = 5'h00;
  // Long PWM period so a pulse outlasts dead time plus the two-flop lag
  logic [3:0] osc = 4'h0;

  always @(posedge pclk) begin
    osc <= osc + 4'h1;
    if (ss_discharge_en) begin
      ss_v <= 6'h00;
    end else if (ss_charge_en && ss_v < 6'h21) begin
      ss_v <= ss_v + 6'h01;
    end
    if (delay_capacitor_pin_fast_discharge) begin
      cd_v <= 5'h00;
    end else if (delay_capacitor_pin_pg_charge && cd_v < 5'h19) begin
      cd_v <= cd_v + 5'h01;
    end
  end

  always_comb begin
    pins = '0;
    pins.bias_por_ok = bias_ok;
    pins.ss_above_1v = ss_v >= 6'h0A;
    pins.ss_at_3v3 = ss_v == 6'h21;
    pins.ss_empty = ss_v == 6'h00;
    pins.pwm_demand = !osc[3];
    pins.osc_cycle = osc[3];
    // Switch node only sags while the high side conducts
    pins.phase_below_overcurrent_threshold_pin = oc & high_side_gate;
    pins.phase_negative = low_side_gate & (ss_v != 6'h21);
    pins.hs_gs_low = !high_side_gate;
    pins.ls_gs_low = !low_side_gate;
    pins.fb_in_window = !uv & !ov;
    pins.fb_below_uv = uv;
    pins.fb_above_ov = ov;
    pins.temp_over_hi = hot;
    pins.temp_below_lo = !hot;
    pins.delay_capacitor_pin_at_2v5 = cd_v == 5'h19;
    pins.delay_capacitor_pin_empty = cd_v == 5'h00;
    {pins.margin_set_mode_pin, pins.margin_select_a, pins.margin_select_b} = strap;
  end
endmodule // bfms_stage_model
`default_nettype wire

// ===== verif/buck_fault_and_mode_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module buck_fault_and_mode_sequencer_tb;
  import bfms_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, high_side_gate, low_side_gate, gate_drive_en, ss_charge_en;
  logic ss_discharge_en, use_internal_ref, margin_current_en, margin_raise, delay_capacitor_pin_pg_charge;
  logic delay_capacitor_pin_fast_discharge, power_good, power_good_oe, ref_track_en, delay_capacitor_pin_slew_charge, delay_capacitor_pin_slew_discharge;
  logic bias_ok = 1'b0, oc = 1'b0, uv = 1'b0, ov = 1'b0, hot = 1'b0, top_q = 1'b0;
  logic [2:0] strap = 3'h6;
  bfms_pins_t pins;
  int n_fail = 0, num_checks = 0, n_top = 0;

  always #50 pclk = ~pclk;

  // Count soft-start ramps reaching the top
  always @(posedge pclk) begin
    top_q <= pins.ss_at_3v3;
    if (pins.ss_at_3v3 && !top_q) n_top <= n_top + 1;
  end

  bfms_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins, .high_side_gate, .low_side_gate, .gate_drive_en, .ss_charge_en,
    .ss_discharge_en, .ref_track_en, .use_internal_ref, .margin_current_en, .margin_raise,
    .delay_capacitor_pin_pg_charge, .delay_capacitor_pin_slew_charge, .delay_capacitor_pin_slew_discharge, .delay_capacitor_pin_fast_discharge,
    .power_good, .power_good_oe);

  bfms_stage_model i_stage (.pclk, .high_side_gate, .low_side_gate, .ss_charge_en,
    .ss_discharge_en, .delay_capacitor_pin_pg_charge, .delay_capacitor_pin_fast_discharge, .bias_ok, .oc, .uv, .ov, .hot,
    .strap, .pins);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Idle edge first so a release never meets a new setup in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
    int i;
    for (i = 0; i < 3000; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if ((rd[7:0] & m) === v) return;
    end
    n_fail++;
    $display("mismatch at %0t got %0h exp %0h", $time, rd, v);
    stop_test();
  endtask

  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'(CTRL_EN_RST));
    apb(1'b1, OFS_STATUS, 32'hFF);
    chk(32'(er), 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h7, 32'(ST_OFF));
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    chk(32'({gate_drive_en, power_good_oe}), 32'h1);
    chk(32'({delay_capacitor_pin_slew_charge, delay_capacitor_pin_slew_discharge}), 32'h0);
    $display("test regs end");
  endtask

  task automatic t_start();
    bias_ok <= 1'b1;
    wait_st(8'h07, 8'(ST_RUN));
    chk(32'(gate_drive_en), 32'h1);
    chk(32'(ref_track_en), 32'h1);
    wait_st(8'h08, 8'h08);
    chk(32'({power_good, power_good_oe}), 32'h2);
    $display("test start end");
  endtask

  task automatic t_mode();
    strap <= 3'h4;
    repeat (6) @(posedge pclk);
    chk(32'({use_internal_ref, margin_current_en}), 32'h0);
    strap <= 3'h1;
    wait_st(8'h80, 8'h80);
    chk(32'(margin_raise), 32'h1);
    chk(32'({delay_capacitor_pin_slew_charge, delay_capacitor_pin_slew_discharge}), 32'h2);
    strap <= 3'h3;
    repeat (6) @(posedge pclk);
    chk(32'({margin_current_en, margin_raise}), 32'h3);
    strap <= 3'h2;
    repeat (6) @(posedge pclk);
    chk(32'({margin_current_en, margin_raise}), 32'h2);
    strap <= 3'h0;
    repeat (6) @(posedge pclk);
    chk(32'(margin_current_en), 32'h0);
    chk(32'({delay_capacitor_pin_slew_charge, delay_capacitor_pin_slew_discharge}), 32'h1);
    strap <= 3'h6;
    repeat (6) @(posedge pclk);
    chk(32'(use_internal_ref), 32'h1);
    $display("test mode end");
  endtask

  task automatic t_oc();
    int base;
    oc <= 1'b1;
    wait_st(8'h07, 8'(ST_DISCH));
    oc <= 1'b0;
    base = n_top;
    apb(1'b0, OFS_HICCUP, 32'h0);
    chk(rd, 32'h1);
    wait_st(8'h07, 8'(ST_DUMMY));
    chk(32'({high_side_gate, low_side_gate}), 32'h0);
    wait_st(8'h07, 8'(ST_RUN));
    chk(32'(n_top - base), 32'h4);
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b0, OFS_HICCUP, 32'h0);
    chk(rd, 32'h0);
    $display("test overcurrent end");
  endtask

  task automatic t_ov();
    ov <= 1'b1;
    wait_st(8'h40, 8'h40);
    chk(32'(low_side_gate), 32'h1);
    wait_st(8'h07, 8'(ST_OVOFF));
    chk(32'(gate_drive_en), 32'h0);
    ov <= 1'b0;
    uv <= 1'b1;
    wait_st(8'h07, 8'(ST_DISCH));
    uv <= 1'b0;
    wait_st(8'h07, 8'(ST_RUN));
    apb(1'b0, OFS_HICCUP, 32'h0);
    chk(rd, 32'h1);
    $display("test overvoltage end");
  endtask

  task automatic t_hot();
    hot <= 1'b1;
    wait_st(8'h10, 8'h10);
    repeat (2) @(posedge pclk);
    chk(32'({high_side_gate, low_side_gate}), 32'h0);
    hot <= 1'b0;
    wait_st(8'h10, 8'h00);
    apb(1'b1, OFS_CTRL, 32'h0);
    wait_st(8'h07, 8'(ST_OFF));
    chk(32'({gate_drive_en, power_good_oe}), 32'h1);
    $display("test thermal end");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_start();
    t_mode();
    t_oc();
    t_ov();
    t_hot();
    stop_test();
  end
endmodule // buck_fault_and_mode_sequencer_tb
`default_nettype wire
